// [core/rss_defs.vh]
// Constants for the reset source sequencer.
`ifndef RSS_DEFS_VH
`define RSS_DEFS_VH
// ****************************************
// Register map
// ****************************************
`define RSS_ADDR_STATUS 4'h0
`define RSS_ADDR_OSC 4'h1
`define RSS_ADDR_CTRL 4'h2
`define RSS_ADDR_STATE 4'h3
// ****************************************
// Status bit positions
// ****************************************
`define RSS_BIT_POR 0
`define RSS_BIT_BOR 1
`define RSS_BIT_IDLE 2
`define RSS_BIT_SLEEP 3
`define RSS_BIT_WATCHDOG_TIMEOUT_FLAG 4
`define RSS_BIT_WATCHDOG_SOFT_ENABLE 5
`define RSS_BIT_SWR 6
`define RSS_BIT_PIN_RESET_FLAG 7
`define RSS_BIT_VREGS 8
`define RSS_BIT_IOP 14
`define RSS_BIT_TRAP 15
`define RSS_STATUS_MASK 16'hC1FF
`define RSS_POR_VALUE 16'h0003
// ****************************************
// Timing, 20 MHz core clock
// ****************************************
`define RSS_CLK_MHZ 20
`define RSS_T_POR_US 10
`define RSS_T_STARTUP_REG_US 20
`define RSS_T_POWER_UP_TIMER_MS 64
`define RSS_T_RST_US 20
`define RSS_T_LOCK_US 20
`define RSS_T_CLOCK_FAIL_MONITOR_US 500
`define RSS_CYC_POR (`RSS_T_POR_US * `RSS_CLK_MHZ)
`define RSS_CYC_STARTUP_REG (`RSS_T_STARTUP_REG_US * `RSS_CLK_MHZ)
`define RSS_CYC_POWER_UP_TIMER (`RSS_T_POWER_UP_TIMER_MS * 1000 * `RSS_CLK_MHZ)
`define RSS_CYC_RST (`RSS_T_RST_US * `RSS_CLK_MHZ)
`define RSS_CYC_LOCK (`RSS_T_LOCK_US * `RSS_CLK_MHZ)
`define RSS_CYC_CLOCK_FAIL_MONITOR (`RSS_T_CLOCK_FAIL_MONITOR_US * `RSS_CLK_MHZ)
`define RSS_OST_COUNT 1024
`endif

// [core/rss_sync.v]
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/10ps
`default_nettype none
module rss_sync #(
  parameter WIDTH = 1
) (
  input wire core_clk,
  input wire rst_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= {WIDTH{1'b0}};
      s2_reg <= {WIDTH{1'b0}};
      s3_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // A change counts only once stages two and three agree.
      sync_out <= (s2_reg & s3_reg) | (sync_out & (s2_reg | s3_reg));
    end
  end
endmodule
`default_nettype wire

// [core/rss_osc_timer.v]
// Oscillator start-up and PLL lock timer for the clock release.
`timescale 1ns/10ps
`default_nettype none
`include "rss_defs.vh"
module rss_osc_timer #(
  parameter LOCK_CYC = `RSS_CYC_LOCK
) (
  input wire core_clk,
  input wire rst_n,
  input wire start,
  input wire use_crystal,
  input wire use_pll,
  input wire osc_tick,
  output reg clock_ready
);
  reg [9:0] ost_reg;
  reg ost_done_reg;
  reg [15:0] lock_reg;
  reg running_reg;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ost_reg <= 10'h000;
      ost_done_reg <= 1'b0;
      lock_reg <= 16'h0000;
      running_reg <= 1'b0;
      clock_ready <= 1'b0;
    end
    else if (start)
    begin
      ost_reg <= 10'h000;
      ost_done_reg <= ~use_crystal;
      lock_reg <= 16'h0000;
      running_reg <= 1'b1;
      clock_ready <= 1'b0;
    end
    else if (running_reg)
    begin
      if (!ost_done_reg && osc_tick)
      begin
        // Ten bits wrap after 1024 oscillator periods.
        ost_reg <= ost_reg + 10'h001;
        if (ost_reg == 10'h3FF)
          ost_done_reg <= 1'b1;
      end
      if (ost_done_reg)
      begin
        if (!use_pll || lock_reg == LOCK_CYC[15:0] - 16'h0001)
        begin
          clock_ready <= 1'b1;
          running_reg <= 1'b0;
        end
        else
          lock_reg <= lock_reg + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// [core/rss_top.v]
// Reset source sequencer: source merge, cause flags, release timing.
`timescale 1ns/10ps
`default_nettype none
`include "rss_defs.vh"
// What this block does
// - Any active reset source asserts system reset.
// - Seven sources merged into system reset.
// - Power-on clears flags, sets power-on flag.
// - Software writes flags; never causes reset.
// - Each source sets own flag; pin flag.
// - Trap and illegal-op flags at 15, 14.
// - Watchdog flag cleared by power-save, POR, BOR.
// - Brown-out flag set by BOR or POR.
// - Fuse set means watchdog always enabled.
// - Switching on: POR/BOR fuses, others written OSC value.
// - Switching off: fuses select clock always.
// - Release after power-on and startup delays.
// - POR holds power-on, startup, internal delays.
// - Startup 20 us regulated, else 64 ms.
// - Every reset adds 20 us internal interval.
// - Crystal start-up counts 1024 oscillator periods.
// - PLL lock wait 20 us, after crystal count.
// - Oscillator waits overlap the release delays.
// - No execution until valid clock released.
// - Monitor starts at release; fallback to RC.
// - Crystal or PLL adds monitor start delay.
// - Other registers reset alike for all types; OSC and CTRL writes kept.
module rss_top #(
  parameter POWER_UP_TIMER_CYC = `RSS_CYC_POWER_UP_TIMER,
  parameter CLOCK_FAIL_MONITOR_CYC = `RSS_CYC_CLOCK_FAIL_MONITOR,
  parameter LOCK_CYC = `RSS_CYC_LOCK
) (
  input wire core_clk,
  input wire reset_n,
  input wire por_event,
  input wire brown_out_reset,
  input wire master_clear_pin_n,
  input wire reset_instr,
  input wire watchdog_timeout,
  input wire trap_conflict,
  input wire illegal_op,
  input wire power_save_instr,
  input wire power_save_sleep,
  input wire power_save_idle,
  input wire wake_from_sleep,
  input wire regulator_enable,
  input wire watchdog_fuse_enable,
  input wire clock_switch_enable,
  input wire [2:0] initial_osc_select,
  input wire clock_valid,
  input wire osc_tick,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [15:0] reg_rdata,
  output reg system_reset_out,
  output reg cpu_run,
  output reg watchdog_enable,
  output reg [2:0] current_osc_select,
  output reg clock_fail_monitor,
  output reg switch_to_fast_rc
);
  // ****************************************
  // Reset release and input synchronisation
  // ****************************************
  localparam ST_HOLD = 3'h0;
  localparam ST_POR = 3'h1;
  localparam ST_START = 3'h2;
  localparam ST_RST = 3'h3;
  localparam ST_RUN = 3'h4;
  localparam ST_SLEEP = 3'h5;
  // Delay counts are cut to the counter width on purpose.
  localparam POR_CYC = `RSS_CYC_POR;
  localparam STARTUP_REG_CYC = `RSS_CYC_STARTUP_REG;
  localparam RST_CYC = `RSS_CYC_RST;
  reg rst_a_reg;
  reg rst_n_reg;
  wire [6:0] src_sync;
  wire bor_s;
  wire master_clear_pin_s;
  wire wdt_s;
  wire trap_s;
  wire iop_s;
  wire swr_s;
  wire porsrc_s;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [21:0] cnt_reg;
  reg [21:0] cnt_next;
  reg [15:0] status_reg;
  reg [2:0] osc_ctl_reg;
  reg [1:0] osc_mode_reg;
  reg [21:0] clock_fail_monitor_cnt_reg;
  reg clock_fail_monitor_wait_reg;
  reg por_seen_reg;
  reg bor_seen_reg;
  reg wake_reg;
  reg osc_start_reg;
  wire clock_ready;
  wire any_src;
  wire waking;
  wire [21:0] startup_cyc;
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_a_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_a_reg <= 1'b1;
      rst_n_reg <= rst_a_reg;
    end
  end
  // Pin-level sources come from outside this clock domain.
  rss_sync #(
    .WIDTH(7)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n_reg),
    .async_in({por_event, brown_out_reset, ~master_clear_pin_n, watchdog_timeout,
      trap_conflict, illegal_op, reset_instr}),
    .sync_out(src_sync)
  );
  assign porsrc_s = src_sync[6];
  assign bor_s = src_sync[5];
  assign master_clear_pin_s = src_sync[4];
  assign wdt_s = src_sync[3];
  assign trap_s = src_sync[2];
  assign iop_s = src_sync[1];
  assign swr_s = src_sync[0];
  assign any_src = |src_sync;
  assign startup_cyc = regulator_enable ? STARTUP_REG_CYC[21:0] : POWER_UP_TIMER_CYC[21:0];
  // With the regulator on, a wake from sleep pays the startup delay without asserting system reset.
  assign waking = state_next == ST_START && (state_reg == ST_SLEEP || wake_reg);
  // ****************************************
  // Release sequencer
  // ****************************************
  always @*
  begin
    state_next = state_reg;
    cnt_next = cnt_reg + 22'd1;
    case (state_reg)
      ST_HOLD:
      begin
        cnt_next = 22'd0;
        if (!any_src)
        begin
          if (por_seen_reg)
            state_next = ST_POR;
          else if (bor_seen_reg)
            state_next = ST_START;
          else
            state_next = ST_RST;
        end
      end
      ST_POR:
      begin
        if (cnt_reg == POR_CYC[21:0] - 22'd1)
        begin
          state_next = ST_START;
          cnt_next = 22'd0;
        end
      end
      ST_START:
      begin
        if (cnt_reg == startup_cyc - 22'd1)
        begin
          state_next = wake_reg ? ST_RUN : ST_RST;
          cnt_next = 22'd0;
        end
      end
      ST_RST:
      begin
        if (cnt_reg == RST_CYC[21:0] - 22'd1)
          state_next = ST_RUN;
      end
      ST_RUN:
      begin
        cnt_next = 22'd0;
        if (power_save_instr && power_save_sleep)
          state_next = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        cnt_next = 22'd0;
        // Waking with the regulator on pays the startup delay again.
        if (wake_from_sleep)
          state_next = regulator_enable ? ST_START : ST_RUN;
      end
      default:
      begin
        state_next = ST_HOLD;
        cnt_next = 22'd0;
      end
    endcase
    if (any_src)
    begin
      state_next = ST_HOLD;
      cnt_next = 22'd0;
    end
  end
  always @(posedge core_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      state_reg <= ST_HOLD;
      cnt_reg <= 22'd0;
      por_seen_reg <= 1'b1;
      bor_seen_reg <= 1'b0;
      wake_reg <= 1'b0;
      osc_start_reg <= 1'b0;
      system_reset_out <= 1'b1;
      cpu_run <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (porsrc_s)
        por_seen_reg <= 1'b1;
      else if (state_reg == ST_POR)
        por_seen_reg <= 1'b0;
      if (bor_s)
        bor_seen_reg <= 1'b1;
      else if (state_reg == ST_START)
        bor_seen_reg <= 1'b0;
      wake_reg <= waking;
      // Oscillator waits start with the reset, in parallel with release delays.
      osc_start_reg <= any_src && state_reg != ST_HOLD;
      system_reset_out <= ~(state_next == ST_RUN || state_next == ST_SLEEP || waking);
      cpu_run <= state_next == ST_RUN && clock_ready;
    end
  end
  rss_osc_timer #(
    .LOCK_CYC(LOCK_CYC)
  ) u_osc (
    .core_clk(core_clk),
    .rst_n(rst_n_reg),
    .start(osc_start_reg || (state_reg == ST_HOLD && !any_src)),
    .use_crystal(osc_mode_reg[0]),
    .use_pll(osc_mode_reg[1]),
    .osc_tick(osc_tick),
    .clock_ready(clock_ready)
  );
  // ****************************************
  // Cause flags, clock selection, monitor
  // ****************************************
  always @(posedge core_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      status_reg <= `RSS_POR_VALUE;
      osc_ctl_reg <= 3'h0;
      osc_mode_reg <= 2'h0;
      current_osc_select <= 3'h0;
      watchdog_enable <= 1'b0;
      reg_rdata <= 16'h0000;
      clock_fail_monitor_cnt_reg <= 22'd0;
      clock_fail_monitor_wait_reg <= 1'b0;
      clock_fail_monitor <= 1'b0;
      switch_to_fast_rc <= 1'b0;
    end
    else
    begin
      if (reg_write && reg_addr == `RSS_ADDR_STATUS)
        status_reg <= reg_wdata & `RSS_STATUS_MASK;
      if (reg_write && reg_addr == `RSS_ADDR_OSC)
        osc_ctl_reg <= reg_wdata[14:12];
      if (reg_write && reg_addr == `RSS_ADDR_CTRL)
        osc_mode_reg <= reg_wdata[1:0];
      if (power_save_instr)
      begin
        status_reg[`RSS_BIT_WATCHDOG_TIMEOUT_FLAG] <= 1'b0;
        status_reg[`RSS_BIT_SLEEP] <= power_save_sleep | status_reg[`RSS_BIT_SLEEP];
        status_reg[`RSS_BIT_IDLE] <= power_save_idle | status_reg[`RSS_BIT_IDLE];
      end
      // Hardware events come last so a set wins over a software clear.
      if (bor_s)
      begin
        status_reg[`RSS_BIT_TRAP] <= 1'b0;
        status_reg[`RSS_BIT_IOP] <= 1'b0;
        status_reg[`RSS_BIT_SWR] <= 1'b0;
        status_reg[`RSS_BIT_WATCHDOG_TIMEOUT_FLAG] <= 1'b0;
        status_reg[`RSS_BIT_SLEEP] <= 1'b0;
        status_reg[`RSS_BIT_IDLE] <= 1'b0;
        status_reg[`RSS_BIT_BOR] <= 1'b1;
      end
      if (master_clear_pin_s)
        status_reg[`RSS_BIT_PIN_RESET_FLAG] <= 1'b1;
      if (swr_s)
        status_reg[`RSS_BIT_SWR] <= 1'b1;
      if (wdt_s)
        status_reg[`RSS_BIT_WATCHDOG_TIMEOUT_FLAG] <= 1'b1;
      if (trap_s)
        status_reg[`RSS_BIT_TRAP] <= 1'b1;
      if (iop_s)
        status_reg[`RSS_BIT_IOP] <= 1'b1;
      if (porsrc_s)
        status_reg <= `RSS_POR_VALUE;
      watchdog_enable <= watchdog_fuse_enable | status_reg[`RSS_BIT_WATCHDOG_SOFT_ENABLE];
      if (state_reg == ST_HOLD && !any_src)
      begin
        if (!clock_switch_enable || por_seen_reg || bor_seen_reg)
          current_osc_select <= initial_osc_select;
        else
          current_osc_select <= osc_ctl_reg;
      end
      reg_rdata <= 16'h0000;
      if (reg_read)
      begin
        case (reg_addr)
          `RSS_ADDR_STATUS: reg_rdata <= status_reg;
          `RSS_ADDR_OSC: reg_rdata <= {1'b0, current_osc_select, 12'h000};
          `RSS_ADDR_CTRL: reg_rdata <= {14'h0000, osc_mode_reg};
          `RSS_ADDR_STATE: reg_rdata <= {11'h000, clock_ready, cpu_run, state_reg};
          default: reg_rdata <= 16'h0000;
        endcase
      end
      // Crystal and PLL sources get extra settling time before monitoring.
      if (system_reset_out)
      begin
        clock_fail_monitor_cnt_reg <= 22'd0;
        clock_fail_monitor_wait_reg <= |osc_mode_reg;
        clock_fail_monitor <= 1'b0;
      end
      else if (clock_fail_monitor_wait_reg)
      begin
        clock_fail_monitor_cnt_reg <= clock_fail_monitor_cnt_reg + 22'd1;
        if (clock_fail_monitor_cnt_reg == CLOCK_FAIL_MONITOR_CYC[21:0] - 22'd1)
          clock_fail_monitor_wait_reg <= 1'b0;
      end
      else
        clock_fail_monitor <= 1'b1;
      if (system_reset_out)
        switch_to_fast_rc <= 1'b0;
      else if (clock_fail_monitor && !clock_valid)
        switch_to_fast_rc <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [tb/rss_checker_sva.sv]
// Port checker for the reset source sequencer.
`timescale 1ns/10ps
`default_nettype none
module rss_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic por_event,
  input wire logic brown_out_reset,
  input wire logic master_clear_pin_n,
  input wire logic reset_instr,
  input wire logic watchdog_timeout,
  input wire logic trap_conflict,
  input wire logic illegal_op,
  input wire logic watchdog_fuse_enable,
  input wire logic clock_switch_enable,
  input wire logic [2:0] initial_osc_select,
  input wire logic clock_valid,
  input wire logic [3:0] reg_addr,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic system_reset_out,
  input wire logic cpu_run,
  input wire logic watchdog_enable,
  input wire logic [2:0] current_osc_select,
  input wire logic clock_fail_monitor,
  input wire logic switch_to_fast_rc
);
  // ****************************************
  // Helper counters
  // ****************************************
  // Quiet time is counted from the pins, so it includes the synchroniser delay.
  logic src;
  logic [15:0] quiet_reg;
  logic [2:0] age_reg;
  assign src = por_event | brown_out_reset | !master_clear_pin_n | reset_instr |
    watchdog_timeout | trap_conflict | illegal_op;
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      quiet_reg <= 16'h0000;
      age_reg <= 3'h0;
    end
    else
    begin
      quiet_reg <= src ? 16'h0000 : (quiet_reg == 16'hFFFF ? quiet_reg : quiet_reg + 16'h0001);
      age_reg <= (age_reg == 3'h7) ? age_reg : age_reg + 3'h1;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // ****************************************
  // Properties
  // ****************************************
  property p_src_reset;
    $rose(src) |-> ##[1:8] system_reset_out;
  endproperty
  a_src_reset: assert property (p_src_reset) else $error("source did not raise reset");
  property p_src_held;
    src [*8] |-> system_reset_out;
  endproperty
  a_src_held: assert property (p_src_held) else $error("reset low with source held");
  property p_release;
    $fell(system_reset_out) |-> quiet_reg >= 16'h0190;
  endproperty
  a_release: assert property (p_release) else $error("reset released too early");
  property p_run;
    cpu_run |-> !system_reset_out;
  endproperty
  a_run: assert property (p_run) else $error("running during reset");
  property p_sw;
    quiet_reg > 16'h0008 && !system_reset_out |=> !system_reset_out;
  endproperty
  a_sw: assert property (p_sw) else $error("reset without a source");
  property p_gap;
    reg_read && reg_addr == 4'h0 |=> reg_rdata[13:9] == 5'h00;
  endproperty
  a_gap: assert property (p_gap) else $error("status gap bits not zero");
  property p_idle;
    !reg_read || reg_addr > 4'h3 |=> reg_rdata == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not zero");
  property p_wdt_fuse;
    age_reg == 3'h7 && watchdog_fuse_enable && $past(watchdog_fuse_enable) |-> watchdog_enable;
  endproperty
  a_wdt_fuse: assert property (p_wdt_fuse) else $error("watchdog off with fuse set");
  property p_osc_fuse;
    $fell(system_reset_out) && !clock_switch_enable |-> current_osc_select == initial_osc_select;
  endproperty
  a_osc_fuse: assert property (p_osc_fuse) else $error("clock not from fuses");
  property p_fast_rc;
    (clock_fail_monitor && !clock_valid) [*2] |-> ##[0:4] switch_to_fast_rc;
  endproperty
  a_fast_rc: assert property (p_fast_rc) else $error("no fallback clock");
  c_release: cover property ($fell(system_reset_out));
  c_run: cover property ($rose(cpu_run));
  c_fast_rc: cover property ($rose(switch_to_fast_rc));
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the reset source sequencer.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int CLOCK_FAIL_MONITOR = 20;
  localparam logic [15:0] FLAG [7] = '{16'h0003, 16'h0002, 16'h0080, 16'h0040, 16'h0010,
    16'h8000, 16'h4000};
  logic core_clk, reset_n, power_save_instr, watchdog_fuse_enable, clock_switch_enable;
  logic clock_valid, osc_tick, tick_en, reg_write, reg_read, system_reset_out, cpu_run;
  logic watchdog_enable, clock_fail_monitor, switch_to_fast_rc;
  logic power_save_sleep, power_save_idle, wake_from_sleep;
  logic [2:0] initial_osc_select, current_osc_select;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [6:0] src;
  int num_errors, samples_checked, cycles, i;
  int seed = 32'h873CA99E;
  rss_top #(.POWER_UP_TIMER_CYC(50), .CLOCK_FAIL_MONITOR_CYC(CLOCK_FAIL_MONITOR), .LOCK_CYC(10)) rss_top_i (.core_clk, .reset_n,
    .por_event(src[0]), .brown_out_reset(src[1]), .master_clear_pin_n(!src[2]),
    .reset_instr(src[3]), .watchdog_timeout(src[4]), .trap_conflict(src[5]),
    .illegal_op(src[6]), .power_save_instr, .power_save_sleep, .power_save_idle,
    .wake_from_sleep, .regulator_enable(1'b1), .watchdog_fuse_enable,
    .clock_switch_enable, .initial_osc_select, .clock_valid, .osc_tick, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .system_reset_out, .cpu_run, .watchdog_enable,
    .current_osc_select, .clock_fail_monitor, .switch_to_fast_rc);
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  // Waiting on the run flag is bounded so a stuck oscillator gate shows as a failure.
  task automatic settle();
    for (int n = 0; n < 3000 && cpu_run !== 1'b1; n++)
      @(posedge core_clk);
    #1 check(cpu_run, 1'b1);
  endtask
  task automatic hit(input int b);
    @(posedge core_clk);
    src[b] <= 1'b1;
    repeat (10) @(posedge core_clk);
    #1 check(system_reset_out, 1'b1);
    @(posedge core_clk);
    src[b] <= 1'b0;
    for (int n = 0; n < 3000 && system_reset_out !== 1'b0; n++)
      @(posedge core_clk);
  endtask
  task automatic report_and_stop();
    $display("Errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    osc_tick <= tick_en;
    cycles++;
    if (cycles == 60000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    src = 7'h00;
    reset_n = 1'b0;
    power_save_instr = 1'b0;
    watchdog_fuse_enable = 1'b1;
    clock_switch_enable = 1'b0;
    initial_osc_select = 3'h2;
    clock_valid = 1'b1;
    power_save_sleep = 1'b0;
    power_save_idle = 1'b0;
    wake_from_sleep = 1'b0;
    tick_en = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    settle();
    rd(4'h0, 16'h0003);
    for (i = 0; i < 4; i++)
    begin
      d = $random(seed);
      wr(4'h0, d);
      rd(4'h0, d & 16'hC1FF);
    end
    rd(4'h9, 16'h0000);
    #1 check(system_reset_out, 1'b0);
    for (i = 1; i < 7; i++)
    begin
      wr(4'h0, 16'h0000);
      hit(i);
      settle();
      rd(4'h0, FLAG[i]);
    end
    wr(4'h0, 16'hC0D0);
    hit(1);
    settle();
    rd(4'h0, 16'h0082);
    wr(4'h0, 16'h0010);
    @(posedge core_clk);
    power_save_instr <= 1'b1;
    power_save_idle <= 1'b1;
    @(posedge core_clk);
    power_save_instr <= 1'b0;
    power_save_idle <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(4'h0, 16'h0004);
    @(posedge core_clk);
    power_save_instr <= 1'b1;
    power_save_sleep <= 1'b1;
    @(posedge core_clk);
    power_save_instr <= 1'b0;
    power_save_sleep <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1 check(cpu_run, 1'b0);
    @(posedge core_clk);
    wake_from_sleep <= 1'b1;
    @(posedge core_clk);
    wake_from_sleep <= 1'b0;
    repeat (100) @(posedge core_clk);
    #1 check(cpu_run, 1'b0);
    check(system_reset_out, 1'b0);
    settle();
    wr(4'h0, 16'hFFFF);
    hit(0);
    settle();
    rd(4'h0, 16'h0003);
    watchdog_fuse_enable <= 1'b0;
    wr(4'h0, 16'h0020);
    repeat (3) @(posedge core_clk);
    #1 check(watchdog_enable, 1'b1);
    wr(4'h0, 16'h0000);
    repeat (3) @(posedge core_clk);
    #1 check(watchdog_enable, 1'b0);
    watchdog_fuse_enable <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 check(watchdog_enable, 1'b1);
    clock_switch_enable <= 1'b1;
    wr(4'h1, 16'h5000);
    hit(3);
    settle();
    check(current_osc_select, 3'h5);
    hit(1);
    settle();
    check(current_osc_select, 3'h2);
    clock_switch_enable <= 1'b0;
    wr(4'h1, 16'h5000);
    hit(3);
    settle();
    check(current_osc_select, 3'h2);
    wr(4'h2, 16'h0003);
    tick_en <= 1'b0;
    hit(3);
    repeat (5) @(posedge core_clk);
    #1 check(clock_fail_monitor, 1'b0);
    repeat (15) @(posedge core_clk);
    #1 check(cpu_run, 1'b0);
    tick_en <= 1'b1;
    repeat (1000) @(posedge core_clk);
    #1 check(cpu_run, 1'b0);
    settle();
    check(clock_fail_monitor, 1'b1);
    repeat (CLOCK_FAIL_MONITOR + 10) @(posedge core_clk);
    clock_valid <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1 check(switch_to_fast_rc, 1'b1);
    clock_valid <= 1'b1;
    report_and_stop();
  end
endmodule
bind rss_top rss_checker rss_checker_i (.core_clk, .reset_n, .por_event, .brown_out_reset,
  .master_clear_pin_n, .reset_instr, .watchdog_timeout, .trap_conflict, .illegal_op,
  .watchdog_fuse_enable, .clock_switch_enable, .initial_osc_select, .clock_valid, .reg_addr,
  .reg_read, .reg_rdata, .system_reset_out, .cpu_run, .watchdog_enable, .current_osc_select,
  .clock_fail_monitor, .switch_to_fast_rc);
`default_nettype wire
